/* File: exec_pkg.sv */
// Shared types and constants for the control and bit instruction unit.
// Assumes an upstream decoder delivers one decoded instruction at a time.
package exec_pkg;

    // Condition code bit positions
    localparam int FLG_C = 0;
    localparam int FLG_V = 1;
    localparam int FLG_Z = 2;
    localparam int FLG_N = 3;
    localparam int FLG_T = 4;
    localparam int FLG_S = 5;
    localparam int FLG_I = 6;

    // Reset values, common bank and I/O page
    localparam logic [7:0] CCR_RST = 8'h20;
    localparam logic [7:0] BP_RST = 8'h00;
    localparam logic [7:0] ILM_RST = 8'h07;
    localparam logic [15:0] SP_RST = 16'h0000;
    localparam logic [31:0] ACC_RST = 32'h0000_0000;
    localparam logic [7:0] COMMON_BANK = 8'h00;
    localparam logic [15:0] IO_PAGE = 16'h0000;

    // Machine cycle counts
    localparam logic [5:0] CYC_ONE = 6'h01;
    localparam logic [5:0] CYC_CCR = 6'h03;
    localparam logic [5:0] CYC_IMM = 6'h02;
    localparam logic [5:0] CYC_EA = 6'h01;
    localparam logic [5:0] CYC_STACK_ADJUST_OP = 6'h03;
    localparam logic [5:0] CYC_BRG_FAST = 6'h01;
    localparam logic [5:0] CYC_BRG_SLOW = 6'h02;
    localparam logic [5:0] CYC_POP_BASE = 6'h07;
    localparam logic [5:0] CYC_POP_PER = 6'h03;
    localparam logic [5:0] CYC_POP_LAST = 6'h02;
    localparam logic [5:0] CYC_PUSH_BASE = 6'h1D;
    localparam logic [5:0] CYC_PUSH_LAST = 6'h03;
    localparam logic [5:0] CYC_PUSH_EMPTY = 6'h08;
    localparam logic [5:0] CYC_LD = 6'h05;
    localparam logic [5:0] CYC_LD_IO = 6'h04;
    localparam logic [5:0] CYC_ST = 6'h07;
    localparam logic [5:0] CYC_ST_IO = 6'h06;
    localparam logic [5:0] CYC_SETCLR = 6'h07;
    localparam logic [5:0] CYC_BR_NT = 6'h07;
    localparam logic [5:0] CYC_BR_NT_IO = 6'h06;
    localparam logic [5:0] CYC_TAS_NT = 6'h09;

    // Bank register selector codes
    localparam logic [2:0] BRG_PROG = 3'h0;
    localparam logic [2:0] BRG_AUX = 3'h1;
    localparam logic [2:0] BRG_SSTK = 3'h2;
    localparam logic [2:0] BRG_USTK = 3'h3;
    localparam logic [2:0] BRG_STK = 3'h4;
    localparam logic [2:0] BRG_DATA = 3'h5;
    localparam logic [2:0] BRG_DPAGE = 3'h6;

    typedef enum logic [4:0] {
        op_nop, op_and_ccr, op_or_ccr, op_ld_bp, op_ld_ilm,
        op_ea_rw, op_ea_acc, op_sp_add8, op_sp_add16, op_ld_brg,
        op_pop_list, op_push_list,
        op_bit_ld, op_bit_st, op_bit_set, op_bit_clr,
        op_br_clr, op_br_set, op_tas_br, op_wait_hi, op_wait_lo,
        op_pfx_aux, op_pfx_data, op_pfx_prog, op_pfx_stack,
        op_pfx_noflag, op_pfx_common
    } op_t;

    typedef enum logic [1:0] {am_dir = 2'h0, am_abs = 2'h1, am_io = 2'h2} amode_t;

    typedef enum logic [2:0] {
        sp_none, sp_aux, sp_data, sp_prog, sp_stack
    } space_t;

    // imm: immediate, bit address or computed effective address
    typedef struct packed {
        op_t op;
        amode_t mode;
        logic [15:0] imm;
        logic [2:0] bp;
        logic [2:0] sel;
        logic [7:0] rlst;
        logic [7:0] rel;
    } instr_t;

    typedef struct packed {
        logic [7:0] prog;
        logic [7:0] aux;
        logic [7:0] sys_stack;
        logic [7:0] user_stack;
        logic [7:0] stack;
        logic [7:0] data;
        logic [7:0] direct_page;
    } bank_regs_t;

    typedef struct packed {
        logic req;
        logic we;
        logic [23:0] addr;
        logic [7:0] wdata;
    } bus_t;

    typedef struct packed {
        logic en;
        logic [7:0] bank;
        logic [2:0] idx;
        logic [15:0] data;
    } rw_t;

endpackage : exec_pkg

/* File: bit_modify.sv */
// Byte bit extract and replace for read-modify-write bit access.
// Purely combinational; caller registers the result.
`timescale 1ns/10ps
module bit_modify (
    input logic [7:0] byte_in,
    input logic [2:0] bp,
    input logic put_val,
    output logic [7:0] byte_out,
    output logic bit_out
);
    // One lane per bit: replace only the addressed one
    for (genvar i = 0; i < 8; i++) begin : g_lane
        assign byte_out[i] = (bp == 3'(i)) ? put_val : byte_in[i];
    end
    assign bit_out = byte_in[bp];
endmodule : bit_modify

/* File: cycle_calc.sv */
// Base execution length and register count for a decoded instruction.
// Branch-taken extension is added by the caller after the bit read.
`timescale 1ns/10ps
module cycle_calc
    import exec_pkg::*;
(
    input exec_pkg::instr_t ins,
    output logic [5:0] cyc,
    output logic [3:0] nregs
);
    logic [2:0] hi;
    logic [2:0] lo;

    // Count of listed registers, highest and lowest index
    always_comb begin
        nregs = 4'h0;
        hi = 3'h0;
        lo = 3'h0;
        for (int i = 7; i >= 0; i--) begin
            if (ins.rlst[i]) begin
                nregs = nregs + 4'h1;
                lo = 3'(i);
            end
        end
        for (int i = 0; i < 8; i++) begin
            if (ins.rlst[i]) begin
                hi = 3'(i);
            end
        end
    end

    // Length per operation; pop and push use the list formulas
    always_comb begin
        case (ins.op)
            op_and_ccr, op_or_ccr: cyc = CYC_CCR;
            op_ld_bp, op_ld_ilm: cyc = CYC_IMM;
            op_ea_rw, op_ea_acc: cyc = CYC_EA;
            op_sp_add8, op_sp_add16: cyc = CYC_STACK_ADJUST_OP;
            op_ld_brg: cyc = (ins.sel >= BRG_DATA) ? CYC_BRG_SLOW : CYC_BRG_FAST;
            op_pop_list: cyc = (nregs == 4'h0) ? CYC_POP_BASE :
                6'(CYC_POP_BASE + CYC_POP_PER * 6'(nregs) + CYC_POP_LAST * 6'(hi));
            op_push_list: cyc = (nregs == 4'h0) ? CYC_PUSH_EMPTY :
                6'(CYC_PUSH_BASE + 6'(nregs) - CYC_PUSH_LAST * 6'(lo));
            op_bit_ld: cyc = (ins.mode == am_io) ? CYC_LD_IO : CYC_LD;
            op_bit_st: cyc = (ins.mode == am_io) ? CYC_ST_IO : CYC_ST;
            op_bit_set, op_bit_clr: cyc = CYC_SETCLR;
            op_br_clr, op_br_set: cyc = (ins.mode == am_io) ? CYC_BR_NT_IO : CYC_BR_NT;
            op_tas_br: cyc = CYC_TAS_NT;
            default: cyc = CYC_ONE;
        endcase
    end
endmodule : cycle_calc

/* File: exec_unit.sv */
// Execution unit for control, prefix and bit manipulation instructions.
// Assumes the bus answers a read combinationally in the same cycle.
//
// Behaviour
// - CONDITION_CODE_REG and/or with 8-bit immediate; all flags may change.
// - Bank pointer and level mask load 8-bit immediate in 2 cycles.
// - Stack adjust adds sign-extended imm8 or imm16; flags unchanged.
// - Bank register to accumulator sets N,Z; 1 or 2 cycles by bank.
// - Space prefix makes next access use that bank; 1 cycle.
// - No-flag prefix blocks implicit flag updates of next instruction; 1 cycle.
// - Common-bank prefix makes next instruction use the common bank.
// - No-op lasts 1 cycle and changes nothing.
// - List pop: 7+3n+2*last cycles, 7 when empty; n file accesses.
// - List push: 29+n-3*last cycles, 8 when empty.
// - Bit load zero-extends bit into accumulator low word, sets N,Z.
// - Bit store is read-modify-write; 7 cycles, 6 for I/O.
// - Bit set/clear by read-modify-write, 7 cycles, flags unchanged.
// - Bit branches branch on 0 or 1; zero flag from tested bit.
// - Direct and absolute bit branch: 8 taken, 7 not taken.
// - I/O bit branch: 7 taken, 6 not taken.
// - Test-and-set branches on 1, sets the bit; 10 or 9 cycles.
// - Wait instructions stall until the I/O bit reaches its level.
// - Effective-address load writes the address, not memory, no flags.
`timescale 1ns/10ps
module exec_unit
    import exec_pkg::*;
(
    input logic ref_clk,
    input logic rst_n,
    input exec_pkg::instr_t instr,
    input logic instr_valid,
    output logic instr_ready,
    input exec_pkg::bank_regs_t bank_regs,
    output exec_pkg::bus_t bus,
    input logic [7:0] bus_rdata,
    output exec_pkg::rw_t rw_wr,
    output logic [31:0] acc,
    output logic [7:0] condition_code_reg,
    output logic [7:0] bank_pointer,
    output logic [7:0] interrupt_level_mask,
    output logic [15:0] stack_ptr,
    output logic [3:0] rf_access_cnt,
    output logic branch_taken,
    output logic [7:0] branch_rel,
    output logic done
);
    import exec_pkg::*;

    typedef enum logic [2:0] {
        st_idle = 3'b001,
        st_exec = 3'b010,
        st_wait = 3'b100
    } state_t;

    state_t st_r;
    instr_t cur_r;
    logic [5:0] step_r;
    logic [5:0] total_r;
    logic [5:0] cyc_base;
    logic [3:0] nregs;
    logic [3:0] cur_nregs;
    space_t space_r;
    logic noflag_r;
    logic common_r;
    logic bit_r;
    logic [7:0] wbyte_r;
    logic [7:0] mod_byte;
    logic rd_bit;
    logic put_val;
    logic accept;
    logic last;
    logic is_pfx;
    logic rd_step;
    logic wr_step;
    logic taken;
    logic wait_hit;
    logic [7:0] bank_sel;
    logic [7:0] brg_val;
    logic [23:0] eff_addr;

    assign instr_ready = (st_r == st_idle);
    assign accept = instr_valid && instr_ready;
    assign last = (st_r == st_exec) && (step_r == 6'(total_r - 6'h01));
    assign is_pfx = (cur_r.op >= op_pfx_aux);

    // Length of the instruction being offered
    cycle_calc u_cyc (
        .ins(instr),
        .cyc(cyc_base),
        .nregs()
    );

    // Register count of the instruction in flight
    cycle_calc u_cur (
        .ins(cur_r),
        .cyc(),
        .nregs(cur_nregs)
    );

    // Value written back into the addressed byte
    always_comb begin
        if (cur_r.op == op_bit_clr) begin
            put_val = 1'b0;
        end else if (cur_r.op == op_bit_st) begin
            put_val = acc[0];
        end else begin
            put_val = 1'b1;
        end
    end

    bit_modify u_bit (
        .byte_in(bus_rdata),
        .bp(cur_r.bp),
        .put_val(put_val),
        .byte_out(mod_byte),
        .bit_out(rd_bit)
    );

    // Bank chosen for memory access, overridden by a space prefix
    always_comb begin
        case (space_r)
            sp_aux: bank_sel = bank_regs.aux;
            sp_prog: bank_sel = bank_regs.prog;
            sp_stack: bank_sel = bank_regs.stack;
            default: bank_sel = bank_regs.data;
        endcase
    end

    // I/O page ignores banks; direct page goes through the page register
    always_comb begin
        if (cur_r.mode == am_io) begin
            eff_addr = {IO_PAGE, cur_r.imm[7:0]};
        end else if (cur_r.mode == am_dir) begin
            eff_addr = {bank_sel, bank_regs.direct_page, cur_r.imm[7:0]};
        end else begin
            eff_addr = {bank_sel, cur_r.imm};
        end
    end

    // Bank register picked by the selector
    always_comb begin
        case (cur_r.sel)
            BRG_PROG: brg_val = bank_regs.prog;
            BRG_AUX: brg_val = bank_regs.aux;
            BRG_SSTK: brg_val = bank_regs.sys_stack;
            BRG_USTK: brg_val = bank_regs.user_stack;
            BRG_STK: brg_val = bank_regs.stack;
            BRG_DATA: brg_val = bank_regs.data;
            default: brg_val = bank_regs.direct_page;
        endcase
    end

    // Read on the first cycle, write back on the second
    assign rd_step = (st_r == st_exec) && (step_r == 6'h00) &&
        (cur_r.op >= op_bit_ld) && (cur_r.op <= op_tas_br);
    assign wr_step = (st_r == st_exec) && (step_r == 6'h01) &&
        ((cur_r.op == op_bit_st) || (cur_r.op == op_bit_set) ||
         (cur_r.op == op_bit_clr) || (cur_r.op == op_tas_br));
    assign taken = ((cur_r.op == op_br_clr) && !rd_bit) ||
        ((cur_r.op == op_br_set) && rd_bit) || ((cur_r.op == op_tas_br) && rd_bit);
    // Wait bit sampled every cycle so the stall ends one cycle after a match
    assign wait_hit = (st_r == st_wait) && (rd_bit == (cur_r.op == op_wait_hi));

    always_comb begin
        bus.req = rd_step || wr_step || (st_r == st_wait);
        bus.we = wr_step;
        bus.addr = eff_addr;
        bus.wdata = wbyte_r;
    end

    // Sequencer; wait instructions never count cycles
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            st_r <= st_idle;
            step_r <= 6'h00;
            total_r <= CYC_ONE;
            cur_r <= '0;
        end else begin
            case (st_r)
                st_idle: begin
                    if (accept) begin
                        cur_r <= instr;
                        step_r <= 6'h00;
                        total_r <= cyc_base;
                        if ((instr.op == op_wait_hi) || (instr.op == op_wait_lo)) begin
                            st_r <= st_wait;
                        end else begin
                            st_r <= st_exec;
                        end
                    end
                end
                st_exec: begin
                    step_r <= 6'(step_r + 6'h01);
                    if (rd_step && taken) begin
                        total_r <= 6'(total_r + 6'h01);
                    end
                    if (last) begin
                        st_r <= st_idle;
                    end
                end
                st_wait: begin
                    if (wait_hit) begin
                        st_r <= st_idle;
                    end
                end
                default: st_r <= st_idle;
            endcase
        end
    end

    // Captured read data for the write-back and flag update
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            bit_r <= 1'b0;
            wbyte_r <= 8'h00;
        end else if (rd_step) begin
            bit_r <= rd_bit;
            wbyte_r <= mod_byte;
        end
    end

    // Prefix state lives until the next non-prefix instruction completes
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            space_r <= sp_none;
            noflag_r <= 1'b0;
            common_r <= 1'b0;
        end else if (last) begin
            case (cur_r.op)
                op_pfx_aux: space_r <= sp_aux;
                op_pfx_data: space_r <= sp_data;
                op_pfx_prog: space_r <= sp_prog;
                op_pfx_stack: space_r <= sp_stack;
                op_pfx_noflag: noflag_r <= 1'b1;
                op_pfx_common: common_r <= 1'b1;
                default: begin
                    space_r <= sp_none;
                    noflag_r <= 1'b0;
                    common_r <= 1'b0;
                end
            endcase
        end else if (wait_hit) begin
            space_r <= sp_none;
            noflag_r <= 1'b0;
            common_r <= 1'b0;
        end
    end

    // Condition codes; the no-flag prefix gates implicit updates only
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            condition_code_reg <= CCR_RST;
        end else if (last) begin
            case (cur_r.op)
                op_and_ccr: condition_code_reg <= condition_code_reg & cur_r.imm[7:0];
                op_or_ccr: condition_code_reg <= condition_code_reg | cur_r.imm[7:0];
                op_ld_brg: begin
                    if (!noflag_r) begin
                        condition_code_reg[FLG_N] <= brg_val[7];
                        condition_code_reg[FLG_Z] <= (brg_val == 8'h00);
                    end
                end
                op_bit_ld, op_br_clr, op_br_set, op_tas_br: begin
                    if (!noflag_r) begin
                        condition_code_reg[FLG_N] <= 1'b0;
                        condition_code_reg[FLG_Z] <= !bit_r;
                    end
                end
                op_bit_st: begin
                    if (!noflag_r) begin
                        condition_code_reg[FLG_N] <= 1'b0;
                        condition_code_reg[FLG_Z] <= !acc[0];
                    end
                end
                default: condition_code_reg <= condition_code_reg;
            endcase
        end
    end

    // Accumulator, bank pointer, level mask and stack pointer
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            acc <= ACC_RST;
            bank_pointer <= BP_RST;
            interrupt_level_mask <= ILM_RST;
            stack_ptr <= SP_RST;
        end else if (last) begin
            case (cur_r.op)
                op_ld_bp: bank_pointer <= cur_r.imm[7:0];
                op_ld_ilm: interrupt_level_mask <= cur_r.imm[7:0];
                op_ea_acc: acc[15:0] <= cur_r.imm;
                op_ld_brg: acc[15:0] <= {8'h00, brg_val};
                op_bit_ld: acc[15:0] <= {15'h0000, bit_r};
                op_sp_add8: stack_ptr <= 16'(stack_ptr + {{8{cur_r.imm[7]}}, cur_r.imm[7:0]});
                op_sp_add16: stack_ptr <= 16'(stack_ptr + cur_r.imm);
                op_pop_list: stack_ptr <= 16'(stack_ptr + {11'h000, cur_nregs, 1'b0});
                op_push_list: stack_ptr <= 16'(stack_ptr - {11'h000, cur_nregs, 1'b0});
                default: stack_ptr <= stack_ptr;
            endcase
        end
    end

    // Completion pulses and register-file side effects
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            done <= 1'b0;
            branch_taken <= 1'b0;
            branch_rel <= 8'h00;
            rf_access_cnt <= 4'h0;
            rw_wr <= '0;
        end else begin
            done <= last || wait_hit;
            branch_taken <= last && (total_r != cyc_base_r());
            branch_rel <= last ? cur_r.rel : branch_rel;
            rw_wr.en <= last && (cur_r.op == op_ea_rw);
            rw_wr.bank <= common_r ? COMMON_BANK : bank_pointer;
            rw_wr.idx <= cur_r.sel;
            rw_wr.data <= cur_r.imm;
            if (last && ((cur_r.op == op_pop_list) || (cur_r.op == op_push_list))) begin
                rf_access_cnt <= cur_nregs;
            end
        end
    end

    // Untaken length of the current instruction, for the taken test
    function automatic logic [5:0] cyc_base_r();
        logic [5:0] c;
        c = (cur_r.mode == am_io) ? CYC_BR_NT_IO : CYC_BR_NT;
        if (cur_r.op == op_tas_br) begin
            c = CYC_TAS_NT;
        end else if ((cur_r.op != op_br_clr) && (cur_r.op != op_br_set)) begin
            c = total_r;
        end
        return c;
    endfunction : cyc_base_r

    // Checks
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!rst_n);

    sequence s_take(op_t o);
        accept && (instr.op == o);
    endsequence

    sequence s_rmw;
        bus.req && !bus.we ##1 bus.req && bus.we;
    endsequence

    AST_NOP_ONE: assert property (s_take(op_nop) |=> ##1 done && $stable(acc) &&
        $stable(condition_code_reg) && $stable(stack_ptr)) else $error("nop misbehaved");
    AST_BP_LOAD: assert property (s_take(op_ld_bp) |-> ##3 done &&
        bank_pointer == $past(instr.imm[7:0], 3)) else $error("bank pointer load wrong");
    AST_SP_FLAGS: assert property (s_take(op_sp_add16) |=>
        $stable(condition_code_reg)[*4]) else $error("stack adjust touched flags");
    AST_SET_RMW: assert property (s_take(op_bit_set) |=> s_rmw ##5 !done ##1 done)
        else $error("bit set sequence wrong");
    AST_BR_TAKEN: assert property (s_take(op_br_clr) ##0 instr.mode != am_io ##1 !rd_bit
        |-> ##8 done && branch_taken) else $error("taken bit branch length wrong");
    AST_BR_IO_NT: assert property (s_take(op_br_clr) ##0 instr.mode == am_io ##1 rd_bit
        |-> ##6 done && !branch_taken) else $error("untaken io branch length wrong");
    AST_TAS: assert property (s_take(op_tas_br) ##1 rd_bit |=> bus.we &&
        bus.wdata[cur_r.bp] ##9 done) else $error("test and set wrong");
    AST_SPACE: assert property (bus.req && cur_r.mode != am_io && space_r == sp_prog
        |-> bus.addr[23:16] == bank_regs.prog) else $error("space prefix not applied");
    AST_PFX_END: assert property (last && !is_pfx |=> space_r == sp_none &&
        !noflag_r && !common_r) else $error("prefix outlived its instruction");
    AST_NOFLAG: assert property (last && noflag_r && cur_r.op inside {op_bit_ld, op_br_clr, op_br_set}
        |=> $stable(condition_code_reg)) else $error("flags changed under no-flag prefix");
    AST_WAIT: assert property (st_r == st_wait |-> bus.req && !bus.we ##1
        done == $past(wait_hit)) else $error("wait bit handling wrong");
    AST_POP_EMPTY: assert property (s_take(op_pop_list) ##0 instr.rlst == 8'h00
        |-> ##7 !done ##1 done) else $error("empty pop length wrong");

endmodule : exec_unit

/* File: mem_model.sv */
// Byte memory and I/O space that answers the execution unit's bus.
// Assumes reads are answered in the same cycle and writes land at the edge.
`timescale 1ns/10ps
module mem_model
    import exec_pkg::*;
(
    input logic ref_clk,
    input exec_pkg::bus_t bus,
    output logic [7:0] bus_rdata
);
    logic [7:0] mem [256];
    logic [7:0] last_r = 8'h00;

    // Low address byte picks the cell; the bench preloads cells directly
    always @(posedge ref_clk) begin
        if (bus.req && bus.we) begin
            mem[bus.addr[7:0]] <= bus.wdata;
        end
        if (bus.req && !bus.we) begin
            last_r <= bus_rdata;
        end
    end

    // Outside a read the data lines show the inverse of the last read
    assign bus_rdata = (bus.req && !bus.we) ? mem[bus.addr[7:0]] : ~last_r;
endmodule : mem_model

/* File: exec_unit_tb.sv */
// Self-checking bench for the control and bit instruction unit.
// Assumes the memory model answers reads; bank registers stay zero until the load test sets prog and direct_page.
`timescale 1ns/10ps
module exec_unit_tb;
    import exec_pkg::*;
    logic ref_clk = 1'b0;
    logic rst_n = 1'b0;
    instr_t instr = '0;
    logic instr_valid = 1'b0;
    logic instr_ready, done, branch_taken;
    bank_regs_t bank_regs = '0;
    bus_t bus;
    logic [7:0] bus_rdata, condition_code_reg, bank_pointer, interrupt_level_mask, branch_rel;
    logic [31:0] acc;
    logic [15:0] stack_ptr;
    logic [3:0] rf_access_cnt;
    rw_t rw_wr;
    int fails = 0;
    int n_checks = 0;
    int len;
    logic taken;
    logic [7:0] rl = 8'h00;

    exec_unit i_exec_unit (.ref_clk(ref_clk), .rst_n(rst_n), .instr(instr),
        .instr_valid(instr_valid), .instr_ready(instr_ready), .bank_regs(bank_regs),
        .bus(bus), .bus_rdata(bus_rdata), .rw_wr(rw_wr), .acc(acc),
        .condition_code_reg(condition_code_reg), .bank_pointer(bank_pointer),
        .interrupt_level_mask(interrupt_level_mask), .stack_ptr(stack_ptr),
        .rf_access_cnt(rf_access_cnt), .branch_taken(branch_taken),
        .branch_rel(branch_rel), .done(done));
    mem_model i_mem_model (.ref_clk(ref_clk), .bus(bus), .bus_rdata(bus_rdata));

    initial begin
        forever #5 ref_clk = ~ref_clk;
    end

    task automatic complete_run();
        $display("checks %0d mismatches %0d", n_checks, fails);
        if (fails == 0 && n_checks > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask : complete_run

    task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
        n_checks++;
        if (got !== exp) begin
            fails++;
            $display("ERROR %0t %s got %0h expected %0h", $time, what, got, exp);
        end
    endtask : chk

    // One instruction; exp 0 skips the length check (waits are open-ended)
    task automatic run(input op_t o, input amode_t m, input logic [15:0] i,
        input logic [2:0] b, input logic [31:0] exp);
        @(negedge ref_clk);
        instr = '{op: o, mode: m, imm: i, bp: b, sel: b, rlst: rl, rel: 8'h10};
        instr_valid = 1'b1;
        @(negedge ref_clk);
        instr_valid = 1'b0;
        len = 0;
        for (int k = 1; k < 300; k++) begin
            @(posedge ref_clk);
            #1;
            if (done === 1'b1) begin
                len = k;
                break;
            end
        end
        if (len == 0) begin
            fails++;
            $display("ERROR %0t no completion", $time);
            complete_run();
        end
        taken = branch_taken;
        if (exp != 0) chk(len, exp, "length");
    endtask : run

    task automatic t_ctrl();
        run(op_nop, am_dir, 16'h0000, 3'h0, 1);
        chk({instr_ready, condition_code_reg}, 9'h120, "nop ccr");
        run(op_or_ccr, am_dir, 16'h000F, 3'h0, 3);
        run(op_and_ccr, am_dir, 16'h00F5, 3'h0, 3);
        chk(condition_code_reg, 8'h25, "ccr and/or");
        run(op_ld_bp, am_dir, 16'h005A, 3'h0, 2);
        run(op_ld_ilm, am_dir, 16'h0003, 3'h0, 2);
        chk({bank_pointer, interrupt_level_mask}, 16'h5A03, "imm loads");
        run(op_sp_add8, am_dir, 16'h00FE, 3'h0, 0);
        chk(stack_ptr, 16'hFFFE, "sp ext8");
        run(op_sp_add16, am_dir, 16'h0010, 3'h0, 0);
        chk({stack_ptr, condition_code_reg}, 24'h000E25, "sp imm16");
        $display("test ctrl done");
    endtask : t_ctrl

    task automatic t_bits();
        i_mem_model.mem[8'h40] = 8'h81;
        run(op_bit_set, am_io, 16'h0040, 3'h3, 7);
        run(op_bit_clr, am_abs, 16'h0040, 3'h7, 7);
        chk({i_mem_model.mem[8'h40], condition_code_reg}, 16'h0925, "set clr");
        $display("test bits done");
    endtask : t_bits

    task automatic t_branch();
        i_mem_model.mem[8'h41] = 8'h04;
        run(op_br_set, am_io, 16'h0041, 3'h2, 7);
        chk({taken, branch_rel, condition_code_reg}, 17'h11021, "io taken");
        run(op_br_clr, am_io, 16'h0041, 3'h2, 6);
        chk({taken, condition_code_reg}, 9'h021, "io not taken");
        run(op_br_clr, am_abs, 16'h0041, 3'h0, 8);
        chk({taken, condition_code_reg}, 9'h125, "abs taken");
        run(op_pfx_noflag, am_dir, 16'h0000, 3'h0, 1);
        run(op_br_set, am_io, 16'h0041, 3'h2, 7);
        chk(condition_code_reg, 8'h25, "flags held");
        run(op_br_set, am_io, 16'h0041, 3'h2, 7);
        chk(condition_code_reg, 8'h21, "prefix cleared");
        run(op_tas_br, am_abs, 16'h0041, 3'h2, 10);
        chk({taken, condition_code_reg}, 9'h121, "tas taken");
        run(op_tas_br, am_abs, 16'h0041, 3'h0, 9);
        chk({taken, i_mem_model.mem[8'h41], condition_code_reg}, 17'h00525, "tas set");
        $display("test branch done");
    endtask : t_branch

    task automatic t_wait();
        i_mem_model.mem[8'h42] = 8'h00;
        fork
            run(op_wait_hi, am_io, 16'h0042, 3'h0, 0);
            begin
                repeat (8) @(negedge ref_clk);
                i_mem_model.mem[8'h42] = 8'h01;
            end
        join
        chk(len, 7, "wait release");
        $display("test wait done");
    endtask : t_wait

    task automatic t_load();
        @(negedge ref_clk);
        bank_regs.prog = 8'h12;
        bank_regs.direct_page = 8'h80;
        run(op_ld_brg, am_dir, 16'h0000, 3'h6, 2);
        chk({acc[15:0], condition_code_reg}, 24'h008029, "brg slow");
        run(op_ld_brg, am_dir, 16'h0000, 3'h0, 1);
        chk({acc[15:0], condition_code_reg}, 24'h001221, "brg fast");
        run(op_bit_ld, am_dir, 16'h0040, 3'h3, 5);
        chk({acc[15:0], condition_code_reg}, 24'h000121, "bit load");
        run(op_bit_st, am_io, 16'h0040, 3'h4, 6);
        run(op_pfx_prog, am_dir, 16'h0000, 3'h0, 1);
        run(op_bit_set, am_abs, 16'h0040, 3'h7, 7);
        chk(i_mem_model.mem[8'h40], 8'h99, "store and space");
        run(op_ea_acc, am_dir, 16'h1234, 3'h0, 1);
        run(op_pfx_common, am_dir, 16'h0000, 3'h0, 1);
        run(op_ea_rw, am_dir, 16'h5678, 3'h5, 1);
        chk(rw_wr, 28'h8055678, "common bank");
        chk(acc[15:0], 16'h1234, "ea acc");
        run(op_wait_lo, am_io, 16'h0042, 3'h1, 1);
        $display("test load done");
    endtask : t_load

    task automatic t_list();
        run(op_pop_list, am_dir, 16'h0000, 3'h0, 7);
        run(op_push_list, am_dir, 16'h0000, 3'h0, 8);
        rl = 8'h0C;
        run(op_pop_list, am_dir, 16'h0000, 3'h0, 19);
        chk({rf_access_cnt, stack_ptr}, 20'h20012, "pop");
        run(op_push_list, am_dir, 16'h0000, 3'h0, 25);
        chk(stack_ptr, 16'h000E, "push");
        $display("test list done");
    endtask : t_list

    initial begin
        repeat (16) @(negedge ref_clk);
        rst_n = 1'b1;
        t_ctrl();
        t_bits();
        t_branch();
        t_wait();
        t_load();
        t_list();
        complete_run();
    end
endmodule : exec_unit_tb
